//--- tx_pattern_pkg.sv
`default_nettype none
package tx_pattern_pkg;
	// ==========================================================
	// Geometry
	localparam int unsigned NUM_CHANNELS = 3;
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned REG_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned BE_WIDTH = 4;

	typedef logic [ADDR_WIDTH-1:0] addr_t;
	typedef logic [DATA_WIDTH-1:0] word_t;
	typedef logic [REG_WIDTH-1:0] reg_t;
	typedef logic [NUM_CHANNELS-1:0] chan_t;

	// ==========================================================
	// Register map (byte addresses)
	localparam addr_t TX_CTRL_CH0_ADDR = 8'h04;
	localparam addr_t TX_CTRL_CH1_ADDR = 8'h0c;
	localparam addr_t TX_CTRL_CH2_ADDR = 8'h14;
	localparam addr_t PRBS_CTRL_ADDR = 8'h20;
	localparam addr_t STATUS_ADDR = 8'h24;

	// ==========================================================
	// Channel transmit control fields
	localparam int unsigned LINE_BUILD_OUT_BIT = 0;
	localparam int unsigned CLOCK_INVERT_BIT = 1;
	localparam int unsigned SEND_ALL_ONES_SELECT_BIT = 2;
	localparam int unsigned INSERT_ERROR_BIT = 4;
	localparam int unsigned DRIVE_MONITOR_BIT = 5;
	localparam reg_t TX_CTRL_WRITE_MASK = 8'h37;
	localparam reg_t TX_CTRL_RESET = 8'h00;

	// ==========================================================
	// PRBS control fields: generator enables low, receiver enables high
	localparam int unsigned PRBS_GEN_LSB = 0;
	localparam int unsigned PRBS_RX_LSB = 4;
	localparam reg_t PRBS_CTRL_WRITE_MASK = 8'h77;
	localparam reg_t PRBS_CTRL_RESET = 8'h00;

	// ==========================================================
	// Status fields
	localparam int unsigned STATUS_PENDING_LSB = 0;
	localparam int unsigned STATUS_FIFO_FULL_BIT = 4;
	localparam int unsigned STATUS_FIFO_EMPTY_BIT = 5;

	// ==========================================================
	// Test pattern generator: 2^15-1 sequence
	localparam int unsigned PRBS_LEN = 15;
	localparam int unsigned PRBS_TAP_A = 14;
	localparam int unsigned PRBS_TAP_B = 13;
	localparam logic [PRBS_LEN-1:0] PRBS_SEED = 15'h7fff;

	localparam word_t UNMAPPED_READ = 32'h00000000;
endpackage
`default_nettype wire

//--- stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(
	parameter int unsigned WIDTH = 3
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (
		output valid,
		output data,
		input ready
	);
	modport snk (
		input valid,
		input data,
		output ready
	);
endinterface
`default_nettype wire

//--- stream_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
	parameter int unsigned WIDTH = 3,
	parameter int unsigned DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	stream_if.snk inp,
	stream_if.src outp,
	output logic full,
	output logic empty
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign full = (count == (PW+1)'(DEPTH));
	assign empty = (count == '0);
	assign inp.ready = ~full;
	assign outp.valid = ~empty;
	assign outp.data = mem[rd_ptr];
	assign push = clk_en & inp.valid & ~full;
	assign pop = clk_en & outp.ready & ~empty;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= inp.data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
			end
			if (push & ~pop) begin
				count <= count + (PW+1)'(1);
			end else if (pop & ~push) begin
				count <= count - (PW+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

//--- tx_channel.sv
`timescale 1ns/10ps
`default_nettype none
module tx_channel (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic advance,
	input wire logic send_all_ones_select,
	input wire logic insert_error,
	input wire logic prbs_gen_en,
	input wire logic prbs_rx_en,
	input wire logic sys_bit,
	output logic line_bit,
	output logic error_pending
);
	import tx_pattern_pkg::*;

	logic [PRBS_LEN-1:0] lfsr;
	logic insert_prev;
	logic insert_rise;
	logic armed;
	logic apply_error;

	// ==========================================================
	// Error request capture
	assign armed = prbs_gen_en & prbs_rx_en;
	assign insert_rise = insert_error & ~insert_prev;
	assign apply_error = advance & armed & error_pending;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			insert_prev <= 1'b0;
		end else if (clk_en) begin
			insert_prev <= insert_error;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			error_pending <= 1'b0;
		end else if (clk_en) begin
			if (insert_rise & armed) begin
				error_pending <= 1'b1;
			end else if (apply_error | ~armed) begin
				error_pending <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pattern generator
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr <= PRBS_SEED;
		end else if (clk_en & advance & prbs_gen_en) begin
			lfsr <= {lfsr[PRBS_LEN-2:0], lfsr[PRBS_TAP_A] ^ lfsr[PRBS_TAP_B]};
		end
	end

	// ==========================================================
	// Line bit selection
	always_comb begin
		if (send_all_ones_select) begin
			line_bit = 1'b1;
		end else if (prbs_gen_en) begin
			line_bit = lfsr[PRBS_LEN-1] ^ apply_error;
		end else begin
			line_bit = sys_bit;
		end
	end
endmodule
`default_nettype wire

//--- tx_test_pattern_control.sv
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - A 0-to-1 change of a channel's error-insert bit flips exactly one bit of its test pattern.
// - The error-insert bit does nothing unless that channel's generator and receiver are enabled.
// - The error-insert bit sits at bit 4 of the transmit control register, is R/W and resets to 0.
// - The all-ones select bit at bit 2 is R/W and acts at every line rate.
// - With all-ones select at 1 the channel sends an unframed continuous run of ones.
// - In all-ones mode the channel disregards system data and sends ones in its place.
// - With all-ones select at 0 and its generator disabled the channel passes system data to the line unchanged.
// - Each of the three channels has its own transmit control register at 0x04, 0x0c and 0x14.
module tx_test_pattern_control (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire tx_pattern_pkg::addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire tx_pattern_pkg::word_t avs_writedata,
	input wire logic [tx_pattern_pkg::BE_WIDTH-1:0] avs_byteenable,
	output tx_pattern_pkg::word_t avs_readdata,
	output logic avs_waitrequest,
	input wire logic sys_valid,
	input wire tx_pattern_pkg::chan_t sys_data,
	output logic sys_ready,
	output logic line_valid,
	output tx_pattern_pkg::chan_t line_data,
	input wire logic line_ready
);
	import tx_pattern_pkg::*;

	reg_t tx_ctrl [NUM_CHANNELS];
	reg_t prbs_ctrl;
	logic bus_ack;
	logic bus_req;
	logic wr_take;
	logic rd_take;
	word_t next_readdata;
	logic fifo_full;
	logic fifo_empty;
	logic load;
	logic src_ok;
	logic any_uses_data;
	chan_t uses_data;
	chan_t chan_bit;
	chan_t pending;
	chan_t gen_en;
	chan_t rx_en;

	stream_if #(.WIDTH(NUM_CHANNELS)) s_in ();
	stream_if #(.WIDTH(NUM_CHANNELS)) s_out ();

	// ==========================================================
	// Avalon-MM slave: one wait state, then the access completes
	assign bus_req = avs_read | avs_write;
	// A frozen clock holds the master off, so no access completes unseen
	assign avs_waitrequest = bus_req & ~(bus_ack & clk_en);
	assign wr_take = clk_en & avs_write & bus_ack & avs_byteenable[0];
	assign rd_take = clk_en & avs_read & ~bus_ack;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else if (clk_en) begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	always_comb begin
		next_readdata = UNMAPPED_READ;
		unique case (avs_address)
			TX_CTRL_CH0_ADDR: next_readdata[REG_WIDTH-1:0] = tx_ctrl[0];
			TX_CTRL_CH1_ADDR: next_readdata[REG_WIDTH-1:0] = tx_ctrl[1];
			TX_CTRL_CH2_ADDR: next_readdata[REG_WIDTH-1:0] = tx_ctrl[2];
			PRBS_CTRL_ADDR: next_readdata[REG_WIDTH-1:0] = prbs_ctrl;
			STATUS_ADDR: begin
				next_readdata[STATUS_PENDING_LSB +: NUM_CHANNELS] = pending;
				next_readdata[STATUS_FIFO_FULL_BIT] = fifo_full;
				next_readdata[STATUS_FIFO_EMPTY_BIT] = fifo_empty;
			end
			default: next_readdata = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= UNMAPPED_READ;
		end else if (rd_take) begin
			avs_readdata <= next_readdata;
		end
	end

	// ==========================================================
	// Control registers; only writable fields take bus data
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				tx_ctrl[i] <= TX_CTRL_RESET;
			end
		end else if (wr_take) begin
			unique case (avs_address)
				TX_CTRL_CH0_ADDR: tx_ctrl[0] <= avs_writedata[REG_WIDTH-1:0] & TX_CTRL_WRITE_MASK;
				TX_CTRL_CH1_ADDR: tx_ctrl[1] <= avs_writedata[REG_WIDTH-1:0] & TX_CTRL_WRITE_MASK;
				TX_CTRL_CH2_ADDR: tx_ctrl[2] <= avs_writedata[REG_WIDTH-1:0] & TX_CTRL_WRITE_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prbs_ctrl <= PRBS_CTRL_RESET;
		end else if (wr_take && avs_address == PRBS_CTRL_ADDR) begin
			prbs_ctrl <= avs_writedata[REG_WIDTH-1:0] & PRBS_CTRL_WRITE_MASK;
		end
	end

	assign gen_en = prbs_ctrl[PRBS_GEN_LSB +: NUM_CHANNELS];
	assign rx_en = prbs_ctrl[PRBS_RX_LSB +: NUM_CHANNELS];

	// ==========================================================
	// System data buffer
	assign s_in.valid = sys_valid;
	assign s_in.data = sys_data;
	assign sys_ready = s_in.ready;

	stream_fifo #(.WIDTH(NUM_CHANNELS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.inp(s_in),
		.outp(s_out),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	// ==========================================================
	// Output stage: a new word loads when the line side takes the old one
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			uses_data[i] = ~tx_ctrl[i][SEND_ALL_ONES_SELECT_BIT] & ~gen_en[i];
		end
	end

	assign any_uses_data = |uses_data;
	assign load = ~line_valid | line_ready;
	assign src_ok = s_out.valid | ~any_uses_data;
	// Buffered words drain even when no channel uses them
	assign s_out.ready = load;

	generate
		for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
			tx_channel u_chan (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.clk_en(clk_en),
				.advance(load & src_ok),
				.send_all_ones_select(tx_ctrl[c][SEND_ALL_ONES_SELECT_BIT]),
				.insert_error(tx_ctrl[c][INSERT_ERROR_BIT]),
				.prbs_gen_en(gen_en[c]),
				.prbs_rx_en(rx_en[c]),
				.sys_bit(s_out.data[c]),
				.line_bit(chan_bit[c]),
				.error_pending(pending[c])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_valid <= 1'b0;
			line_data <= '0;
		end else if (clk_en & load) begin
			line_valid <= src_ok;
			line_data <= chan_bit;
		end
	end
endmodule
`default_nettype wire

//--- tx_test_pattern_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tx_test_pattern_control_properties (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire tx_pattern_pkg::addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire tx_pattern_pkg::word_t avs_writedata,
	input wire logic [tx_pattern_pkg::BE_WIDTH-1:0] avs_byteenable,
	input wire tx_pattern_pkg::word_t avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic sys_valid,
	input wire tx_pattern_pkg::chan_t sys_data,
	input wire logic sys_ready,
	input wire logic line_valid,
	input wire tx_pattern_pkg::chan_t line_data,
	input wire logic line_ready
);
	import tx_pattern_pkg::*;
	// ==========
	// Shadow copy of the channel control registers
	reg_t ctrl [NUM_CHANNELS];
	chan_t ones;
	int idx;
	always_comb begin
		case (avs_address)
			TX_CTRL_CH0_ADDR: idx = 0;
			TX_CTRL_CH1_ADDR: idx = 1;
			TX_CTRL_CH2_ADDR: idx = 2;
			default: idx = 3;
		endcase
		for (int c = 0; c < 3; c++) ones[c] = ctrl[c][SEND_ALL_ONES_SELECT_BIT];
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '{default: TX_CTRL_RESET};
		end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && idx < 3) begin
			ctrl[idx] <= avs_writedata[7:0] & TX_CTRL_WRITE_MASK;
		end
	end
	// ==========
	// Properties
	sequence s_wait;
		(avs_read || avs_write) && avs_waitrequest && clk_en;
	endsequence
	sequence s_done;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_one_wait: assert property (s_wait |=> s_done)
		else $error("bus answer late");
	a_wait_first: assert property (s_done |-> $past(avs_waitrequest))
		else $error("bus answer without wait state");
	a_ctrl_readback: assert property (s_done and avs_read && idx < 3 |->
		avs_readdata == word_t'(ctrl[idx])) else $error("control readback differs");
	a_unmapped_zero: assert property (s_done and avs_read && idx == 3 &&
		avs_address != PRBS_CTRL_ADDR && avs_address != STATUS_ADDR |->
		avs_readdata == UNMAPPED_READ) else $error("unmapped read not zero");
	a_ones_override: assert property (!line_valid || line_ready |=>
		!line_valid || (line_data & $past(ones)) == $past(ones)) else $error("ones missing");
	a_line_hold: assert property (line_valid && !line_ready |=>
		line_valid && $stable(line_data)) else $error("line word changed while stalled");
	a_reset_idle: assert property ($rose(rst_n) |-> !line_valid &&
		avs_readdata == UNMAPPED_READ) else $error("outputs not idle after reset");
	a_drain_frees: assert property (!sys_ready && line_ready |-> ##[1:2] sys_ready)
		else $error("buffer not freed");
endmodule
bind tx_test_pattern_control tx_test_pattern_control_properties props (.ref_clk(ref_clk),
	.rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_valid(sys_valid),
	.sys_data(sys_data), .sys_ready(sys_ready), .line_valid(line_valid),
	.line_data(line_data), .line_ready(line_ready));
`default_nettype wire

//--- sys_source.sv
`timescale 1ns/10ps
`default_nettype none
module sys_source (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic sys_ready,
	output logic sys_valid,
	output tx_pattern_pkg::chan_t sys_data
);
	import tx_pattern_pkg::*;
	// ==========
	// Counting source; word k carries k, idle lines keep moving
	chan_t k;
	chan_t idle;
	assign sys_data = sys_valid ? k : idle;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			k <= '0;
			idle <= '0;
			sys_valid <= 1'b0;
		end else begin
			idle <= idle + 3'h1;
			sys_valid <= en || (sys_valid && !sys_ready);
			if (sys_valid && sys_ready) k <= k + 3'h1;
		end
	end
endmodule
`default_nettype wire

//--- tb_tx_test_pattern_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_tx_test_pattern_control;
	import tx_pattern_pkg::*;
	logic ref_clk = 0;
	logic rst_n = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic line_ready = 0;
	logic src_en = 0;
	addr_t avs_address = '0;
	word_t avs_writedata = '0;
	logic [BE_WIDTH-1:0] avs_byteenable = '0;
	word_t avs_readdata;
	logic avs_waitrequest, sys_valid, sys_ready, line_valid;
	chan_t sys_data, line_data;
	chan_t q[$];
	logic b0[$];
	addr_t ca[3] = '{TX_CTRL_CH0_ADDR, TX_CTRL_CH1_ADDR, TX_CTRL_CH2_ADDR};
	int miscompares = 0;
	int samples_checked = 0;
	int k = 0;
	tx_test_pattern_control uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sys_valid(sys_valid), .sys_data(sys_data), .sys_ready(sys_ready),
		.line_valid(line_valid), .line_data(line_data), .line_ready(line_ready));
	sys_source src (.ref_clk(ref_clk), .rst_n(rst_n), .en(src_en), .sys_ready(sys_ready),
		.sys_valid(sys_valid), .sys_data(sys_data));
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (line_valid && line_ready) q.push_back(line_data);
	// ==========
	// Shared tasks
	task automatic check(input string what, input word_t exp, input word_t got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input addr_t a, input reg_t d, input logic [3:0] be,
		output word_t rd);
		@(posedge ref_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= word_t'(d);
		avs_byteenable <= be;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input addr_t a, input reg_t d);
		word_t x;
		bus(1'b1, a, d, 4'h1, x);
	endtask
	task automatic rdchk(input string what, input addr_t a, input reg_t e);
		word_t x;
		bus(1'b0, a, 8'h00, 4'h1, x);
		check(what, word_t'(e), x);
	endtask
	task automatic take(input int n, input chan_t ones, input chan_t gen);
		chan_t w;
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (q.size() == 0 && t < 200) begin
				@(posedge ref_clk);
				t++;
			end
			w = (q.size() > 0) ? q.pop_front() : 3'hx;
			b0.push_back(w[0]);
			check("line word", word_t'(ones | (chan_t'(k) & ~ones & ~gen)), word_t'(w & ~gen));
			k++;
		end
	endtask
	task automatic drain(input chan_t ones, input chan_t gen);
		src_en <= 1'b0;
		repeat (12) @(posedge ref_clk);
		take(q.size(), ones, gen);
	endtask
	task automatic burst(input reg_t v, input int exp);
		int viol;
		b0.delete();
		take(20, 3'h0, 3'h1);
		wr(TX_CTRL_CH0_ADDR, v);
		take(30, 3'h0, 3'h1);
		viol = 0;
		for (int i = 15; i < b0.size(); i++) if (b0[i] != (b0[i-14] ^ b0[i-15])) viol++;
		check("pattern errors", word_t'(exp), word_t'(viol));
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		for (int c = 0; c < 3; c++) rdchk("control reset", ca[c], 8'h00);
		rdchk("status reset", STATUS_ADDR, 8'h20);
		rdchk("unmapped", 8'hfc, 8'h00);
	endtask
	task automatic t_regs();
		word_t x;
		for (int c = 0; c < 3; c++) begin
			wr(ca[c], 8'hff);
			rdchk("control rw", ca[c], 8'h37);
			rdchk("other channel", ca[(c + 1) % 3], 8'h00);
			bus(1'b1, ca[c], 8'h00, 4'h0, x);
			rdchk("lane off", ca[c], 8'h37);
			wr(ca[c], 8'h00);
		end
	endtask
	task automatic t_stream();
		line_ready <= 1'b1;
		src_en <= 1'b1;
		take(10, 3'h0, 3'h0);
		line_ready <= 1'b0;
		repeat (12) @(posedge ref_clk);
		check("sys ready", '0, word_t'(sys_ready));
		rdchk("status full", STATUS_ADDR, 8'h10);
		line_ready <= 1'b1;
		drain(3'h0, 3'h0);
		rdchk("status empty", STATUS_ADDR, 8'h20);
	endtask
	task automatic t_ones();
		for (int c = 0; c < 3; c++) begin
			wr(ca[c], 8'h04);
			src_en <= 1'b1;
			take(8, chan_t'(1 << c), 3'h0);
			drain(chan_t'(1 << c), 3'h0);
			wr(ca[c], 8'h00);
		end
	endtask
	task automatic t_error();
		wr(PRBS_CTRL_ADDR, 8'h01);
		src_en <= 1'b1;
		take(4, 3'h0, 3'h1);
		burst(8'h10, 0);
		wr(TX_CTRL_CH0_ADDR, 8'h00);
		wr(PRBS_CTRL_ADDR, 8'h11);
		burst(8'h10, 3);
		burst(8'h10, 0);
		drain(3'h0, 3'h1);
		wr(PRBS_CTRL_ADDR, 8'h00);
		wr(TX_CTRL_CH0_ADDR, 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_stream();
		t_ones();
		t_error();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire
